// ==== design/supply_wake_pkg.sv ====
package supply_wake_pkg;

  // Bus and array widths
  localparam int DATA_W = 32;
  localparam int ADDR_W = 32;
  localparam int WAKE_N = 16;

  // Register byte addresses
  localparam logic [31:0] WAKE_CFG_ADDR = 32'h400e1420;
  localparam logic [31:0] STATUS_ADDR   = 32'h400e1424;
  localparam logic [31:0] IRQ_MASK_ADDR = 32'h400e1428;
  localparam logic [31:0] CONTROL_ADDR  = 32'h400e142c;

  // Reset values
  localparam logic [31:0] WAKE_CFG_RESET = 32'h00000000;
  localparam logic [31:0] STICKY_RESET   = 32'h00000000;
  localparam logic [31:0] IRQ_MASK_RESET = 32'h00000000;
  localparam logic [31:0] CONTROL_RESET  = 32'h00000000;

  // Wake input configuration fields
  localparam int ENABLE_LSB   = 0;
  localparam int POLARITY_LSB = 16;

  // Status fields
  localparam int PIN_WAKE_BIT  = 1;
  localparam int MON_WAKE_BIT  = 2;
  localparam int BROWNOUT_BIT  = 3;
  localparam int MON_RESET_BIT = 4;
  localparam int MON_EVENT_BIT = 5;
  localparam int MON_LEVEL_BIT = 6;
  localparam int SLOW_SRC_BIT  = 7;
  localparam int SOURCE_LSB    = 16;

  // Control fields
  localparam int CTRL_DEBOUNCE_LSB  = 0;
  localparam int CTRL_MON_WAKE_BIT  = 4;
  localparam int CTRL_MON_RESET_BIT = 5;

  // Slow tick rate and clear latency
  localparam int          CLK_FREQ_HZ       = 25_000_000;
  localparam int          SLOW_FREQ_HZ      = 32_768;
  localparam int          SLOW_DIV_DEFAULT  = CLK_FREQ_HZ / SLOW_FREQ_HZ;
  localparam logic [1:0]  CLEAR_DELAY_TICKS = 2'h2;

  // Debounce lengths in slow ticks
  localparam logic [15:0] DBC_LEN_IMMEDIATE = 16'h0001;
  localparam logic [15:0] DBC_LEN_3         = 16'h0003;
  localparam logic [15:0] DBC_LEN_32        = 16'h0020;
  localparam logic [15:0] DBC_LEN_512       = 16'h0200;
  localparam logic [15:0] DBC_LEN_4096      = 16'h1000;
  localparam logic [15:0] DBC_LEN_32768     = 16'h8000;

  typedef enum logic [2:0] {
    DBC_SEL_IMMEDIATE = 3'b000,
    DBC_SEL_3         = 3'b001,
    DBC_SEL_32        = 3'b010,
    DBC_SEL_512       = 3'b011,
    DBC_SEL_4096      = 3'b100,
    DBC_SEL_32768     = 3'b101
  } debounce_sel_type;

  // AHB transfer type with a valid transfer
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

endpackage

// ==== design/wake_input_channel.sv ====
`timescale 1ns/10ps
// One wake input: transition detect and debounce on slow ticks
module wake_input_channel
  import supply_wake_pkg::*;
(
  input  wire logic        clk,       // System clock
  input  wire logic        rst,       // Asynchronous reset
  input  wire logic        tick,      // Slow clock enable
  input  wire logic        pin,       // Wake input level
  input  wire logic        enable,    // Input takes part in wake
  input  wire logic        polarity,  // 1 rising, 0 falling
  input  wire logic [15:0] length,    // Debounce length in ticks
  output logic             hit        // One-cycle wake pulse
);

  logic        last;
  logic        armed;
  logic [15:0] count;
  logic        active;

  assign active = (pin == polarity);

  // Transition seen, then active level held for the debounce length
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      last  <= 1'b0;
      armed <= 1'b0;
      count <= 16'h0000;
      hit   <= 1'b0;
    end
    else
    begin
      hit <= 1'b0;
      if (tick)
      begin
        last <= pin;
        if (!enable || !active)
        begin
          armed <= 1'b0;
          count <= 16'h0000;
        end
        else if (last != polarity)
        begin
          if (length == DBC_LEN_IMMEDIATE)
            hit <= 1'b1;
          else
          begin
            armed <= 1'b1;
            count <= 16'h0001;
          end
        end
        else if (armed)
        begin
          if (count + 16'h0001 == length)
          begin
            hit   <= 1'b1;
            armed <= 1'b0;
          end
          else
            count <= count + 16'h0001;
        end
      end
    end
  end

endmodule

// ==== design/supply_wakeup_status_logic.sv ====
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/10ps
// Notes on behaviour
// - Sixteen enable bits in the low half of the wake config let each input wake the core.
// - Sixteen polarity bits in the high half pick falling (0) or rising (1) as the trigger.
// - Reading status clears its sticky flags, but only two slow ticks after the read.
// - Status bit 1 shows that an enabled wake pin has woken the core since the last read.
// - Status bit 2 shows a wake caused by a supply monitor detection since the last read.
// - Status bit 3 shows at least one brownout rising edge since the last read.
// - The brownout flag follows edges only, so a held low supply does not set it again.
// - Status bit 4 shows a supply monitor detection that produced a core reset.
// - Status bit 5 shows any supply monitor detection, whatever its effect.
// - Status bit 6 is the live result of the latest supply measurement, 1 when low.
module supply_wakeup_status_logic
  import supply_wake_pkg::*;
#(
  parameter int SLOW_DIV = SLOW_DIV_DEFAULT
)
(
  input  wire logic                              CLK,           // 25 MHz clock
  input  wire logic                              RST,           // Async reset, high
  input  wire logic                              HSEL,          // Slave select
  input  wire logic [supply_wake_pkg::ADDR_W-1:0] HADDR,        // Byte address
  input  wire logic [1:0]                        HTRANS,        // Transfer type
  input  wire logic                              HWRITE,        // Write access
  input  wire logic [2:0]                        HSIZE,         // Transfer size
  input  wire logic [supply_wake_pkg::DATA_W-1:0] HWDATA,       // Write data
  input  wire logic                              HREADY,        // Bus ready
  output logic      [supply_wake_pkg::DATA_W-1:0] HRDATA,       // Read data
  output logic                                   HREADYOUT,     // Slave ready
  output logic                                   HRESP,         // Response, OKAY
  input  wire logic [supply_wake_pkg::WAKE_N-1:0] WAKE_PIN,     // Wake inputs
  input  wire logic                              MON_DETECT,    // Monitor detection
  input  wire logic                              MON_LOW,       // Latest measure low
  input  wire logic                              BROWNOUT,      // Brownout output
  input  wire logic                              SLOW_SRC_XTAL, // Crystal selected
  output logic                                   CORE_WAKE,     // Wake pulse
  output logic                                   CORE_RESET,    // Reset pulse
  output logic                                   IRQ            // Interrupt level
);

  import supply_wake_pkg::*;

  logic [31:0]       wake_cfg;
  logic [31:0]       sticky;
  logic [31:0]       next_sticky;
  logic [31:0]       irq_mask;
  logic [31:0]       control;
  logic [31:0]       snap;
  logic [31:0]       set_mask;
  logic [31:0]       clear_mask;
  logic [31:0]       status_view;
  logic [31:0]       read_word;
  logic [31:0]       wr_addr;
  logic              wr_pend;
  logic              accept;
  logic              status_rd;
  logic              clr_pending;
  logic [1:0]        clr_ticks;
  logic              clear_go;
  logic [15:0]       div_count;
  logic              slow_tick;
  logic [15:0]       dbc_length;
  logic [WAKE_N-1:0] wake_hit;
  logic              mon_last;
  logic              mon_rise;
  logic              brown_last;
  logic              brown_rise;
  logic              mon_wake;
  logic              mon_reset;
  logic [31:0]       next_irq_mask;

  // Debounce length from the selection code
  function automatic logic [15:0] debounce_length(input logic [2:0] sel);
    logic [15:0] len;
    len = DBC_LEN_IMMEDIATE;
    unique case (sel)
      DBC_SEL_IMMEDIATE: len = DBC_LEN_IMMEDIATE;
      DBC_SEL_3:         len = DBC_LEN_3;
      DBC_SEL_32:        len = DBC_LEN_32;
      DBC_SEL_512:       len = DBC_LEN_512;
      DBC_SEL_4096:      len = DBC_LEN_4096;
      DBC_SEL_32768:     len = DBC_LEN_32768;
      default:           len = DBC_LEN_IMMEDIATE; // Reserved codes
    endcase
    return len;
  endfunction

  assign dbc_length = debounce_length(control[CTRL_DEBOUNCE_LSB +: 3]);

  // Slow clock enable divider
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      div_count <= 16'h0000;
      slow_tick <= 1'b0;
    end
    else if (div_count == 16'(SLOW_DIV - 1))
    begin
      div_count <= 16'h0000;
      slow_tick <= 1'b1;
    end
    else
    begin
      div_count <= div_count + 16'h0001;
      slow_tick <= 1'b0;
    end
  end

  // One channel per wake input
  genvar gi;
  generate
    for (gi = 0; gi < WAKE_N; gi++)
    begin : g_wake
      wake_input_channel u_chan (
        .clk      (CLK),
        .rst      (RST),
        .tick     (slow_tick),
        .pin      (WAKE_PIN[gi]),
        .enable   (wake_cfg[ENABLE_LSB + gi]),
        .polarity (wake_cfg[POLARITY_LSB + gi]),
        .length   (dbc_length),
        .hit      (wake_hit[gi])
      );
    end
  endgenerate

  // Edge detection of monitor and brownout outputs
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      mon_last   <= 1'b0;
      brown_last <= 1'b0;
    end
    else
    begin
      mon_last   <= MON_DETECT;
      brown_last <= BROWNOUT;
    end
  end

  assign mon_rise   = MON_DETECT & ~mon_last;
  assign brown_rise = BROWNOUT & ~brown_last;
  assign mon_wake   = mon_rise & control[CTRL_MON_WAKE_BIT];
  assign mon_reset  = mon_rise & control[CTRL_MON_RESET_BIT];

  // Core wake and reset requests
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      CORE_WAKE  <= 1'b0;
      CORE_RESET <= 1'b0;
    end
    else
    begin
      CORE_WAKE  <= (|wake_hit) | mon_wake;
      CORE_RESET <= mon_reset;
    end
  end

  // Bus address phase decode
  assign accept    = HSEL & HREADY & HTRANS[1];
  assign status_rd = accept & ~HWRITE & (HADDR == STATUS_ADDR);

  // Event set mask
  always_comb
  begin
    set_mask                             = 32'h00000000;
    set_mask[PIN_WAKE_BIT]               = |wake_hit;
    set_mask[MON_WAKE_BIT]               = mon_wake;
    set_mask[BROWNOUT_BIT]               = brown_rise;
    set_mask[MON_RESET_BIT]              = mon_reset;
    set_mask[MON_EVENT_BIT]              = mon_rise;
    set_mask[SOURCE_LSB +: WAKE_N]       = wake_hit;
  end

  // Delayed clear by two slow ticks after a status read
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      clr_pending <= 1'b0;
      clr_ticks   <= 2'h0;
      snap        <= 32'h00000000;
    end
    else if (status_rd)
    begin
      clr_pending <= 1'b1;
      clr_ticks   <= 2'h0;
      snap        <= (clear_go ? 32'h00000000 : snap) | sticky;
    end
    else if (clr_pending && slow_tick)
    begin
      if (clr_ticks == CLEAR_DELAY_TICKS - 2'h1)
      begin
        clr_pending <= 1'b0;
        snap        <= 32'h00000000;
      end
      clr_ticks <= clr_ticks + 2'h1;
    end
  end

  assign clear_go   = clr_pending & slow_tick & (clr_ticks == CLEAR_DELAY_TICKS - 2'h1);
  assign clear_mask = clear_go ? snap : 32'h00000000;
  assign next_sticky = (sticky & ~clear_mask) | set_mask; // Set wins over clear

  // Sticky flags
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      sticky <= STICKY_RESET;
    else
      sticky <= next_sticky;
  end

  // Status word with live levels
  always_comb
  begin
    status_view                = sticky;
    status_view[MON_LEVEL_BIT] = MON_LOW;
    status_view[SLOW_SRC_BIT]  = SLOW_SRC_XTAL;
  end

  // Read multiplexer, unmapped reads zero
  always_comb
  begin
    read_word = 32'h00000000;
    if (HADDR == WAKE_CFG_ADDR)
      read_word = wake_cfg;
    else if (HADDR == STATUS_ADDR)
      read_word = status_view;
    else if (HADDR == IRQ_MASK_ADDR)
      read_word = irq_mask;
    else if (HADDR == CONTROL_ADDR)
      read_word = control;
  end

  // Bus answer, zero wait states
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      HRDATA    <= 32'h00000000;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
      wr_pend   <= 1'b0;
      wr_addr   <= 32'h00000000;
    end
    else
    begin
      wr_pend <= accept & HWRITE;
      if (accept)
        wr_addr <= HADDR;
      if (accept && !HWRITE)
        HRDATA <= read_word;
    end
  end

  // Register writes in the data phase
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      wake_cfg <= WAKE_CFG_RESET;
      irq_mask <= IRQ_MASK_RESET;
      control  <= CONTROL_RESET;
    end
    else if (wr_pend)
    begin
      if (wr_addr == WAKE_CFG_ADDR)
        wake_cfg <= HWDATA;
      if (wr_addr == IRQ_MASK_ADDR)
        irq_mask <= HWDATA;
      if (wr_addr == CONTROL_ADDR)
        control <= {26'h0, HWDATA[5:0]};
    end
  end

  // Mask after this edge, so a mask write shows on the interrupt at once
  assign next_irq_mask = (wr_pend && wr_addr == IRQ_MASK_ADDR) ? HWDATA : irq_mask;

  // Interrupt level from unmasked sticky flags
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      IRQ <= 1'b0;
    else
      IRQ <= |(next_sticky & next_irq_mask);
  end

  // Checks
  a_wake_enable_gate: assert property (@(posedge CLK) disable iff (RST)
    (wake_hit & ~$past(wake_cfg[ENABLE_LSB +: WAKE_N])) == 16'h0000)
    else $error("wake hit on a disabled input");
  a_wake_polarity_match: assert property (@(posedge CLK) disable iff (RST)
    (wake_hit & ($past(WAKE_PIN) ^ $past(wake_cfg[POLARITY_LSB +: WAKE_N]))) == 16'h0000)
    else $error("wake hit with pin at inactive level");
  a_clear_only_late: assert property (@(posedge CLK) disable iff (RST)
    $fell(sticky[PIN_WAKE_BIT]) |-> $past(clear_go) && $past(clr_ticks) == 2'h1)
    else $error("pin flag cleared outside the delayed clear");
  a_read_arms_clear: assert property (@(posedge CLK) disable iff (RST)
    status_rd |=> clr_pending && !clear_go)
    else $error("status read did not arm the clear");
  a_pin_flag_set: assert property (@(posedge CLK) disable iff (RST)
    (|wake_hit) |=> sticky[PIN_WAKE_BIT] && CORE_WAKE)
    else $error("pin wake flag not set");
  a_mon_wake_set: assert property (@(posedge CLK) disable iff (RST)
    (MON_DETECT && !mon_last && control[CTRL_MON_WAKE_BIT]) |=> sticky[MON_WAKE_BIT] && CORE_WAKE)
    else $error("monitor wake flag not set");
  a_brownout_edge: assert property (@(posedge CLK) disable iff (RST)
    $rose(sticky[BROWNOUT_BIT]) |-> $rose($past(BROWNOUT)))
    else $error("brownout flag set without an edge");
  a_brownout_level: assert property (@(posedge CLK) disable iff (RST)
    $past(BROWNOUT, 2) && $past(BROWNOUT) && !$past(sticky[BROWNOUT_BIT])
    |-> !sticky[BROWNOUT_BIT])
    else $error("held brownout level set the flag");
  a_mon_reset_set: assert property (@(posedge CLK) disable iff (RST)
    mon_reset |=> sticky[MON_RESET_BIT] && sticky[MON_EVENT_BIT] && CORE_RESET)
    else $error("monitor reset flag not set");
  a_mon_event_set: assert property (@(posedge CLK) disable iff (RST)
    $rose(MON_DETECT) |=> sticky[MON_EVENT_BIT])
    else $error("monitor event flag not set");
  a_source_flag_set: assert property (@(posedge CLK) disable iff (RST)
    (|wake_hit) |=> (sticky[SOURCE_LSB +: WAKE_N] & $past(wake_hit)) == $past(wake_hit))
    else $error("wake source flag not set");
  a_irq_follows: assert property (@(posedge CLK) disable iff (RST)
    IRQ == (|(sticky & irq_mask)))
    else $error("interrupt does not follow the unmasked flags");
  a_spare_bits_zero: assert property (@(posedge CLK) disable iff (RST)
    (sticky & 32'h0000ffc1) == 32'h00000000)
    else $error("sticky flag set outside the defined bits");
  a_live_level_read: assert property (@(posedge CLK) disable iff (RST)
    status_rd |=> HRDATA[MON_LEVEL_BIT] == $past(MON_LOW))
    else $error("status read missed the live monitor level");
  a_reset_one_cycle: assert property (@(posedge CLK) disable iff (RST)
    CORE_RESET |=> !CORE_RESET)
    else $error("core reset longer than one cycle");

  c_pin_wake:    cover property (@(posedge CLK) disable iff (RST) |wake_hit);
  c_read_clear:  cover property (@(posedge CLK) disable iff (RST) clear_go && snap != 32'h0);
  c_set_at_clear: cover property (@(posedge CLK) disable iff (RST) clear_go && (|set_mask));
  c_brownout:    cover property (@(posedge CLK) disable iff (RST) brown_rise);

endmodule

// ==== test/wake_partner.sv ====
`timescale 1ns/10ps
// Wake pins and supply detectors outside the block
module wake_partner
(
  input  wire logic        clk,        // System clock
  output logic      [15:0] wake_pin,   // Wake input levels
  output logic             mon_detect, // Monitor detection
  output logic             mon_low,    // Latest measure low
  output logic             brownout,   // Brownout output
  output logic             slow_src    // Crystal selected
);
  // Quiet levels at time zero
  initial
  begin
    wake_pin = 16'h0000;
    mon_detect = 1'b0;
    mon_low = 1'b0;
    brownout = 1'b0;
    slow_src = 1'b0;
  end

  // Set one pin level
  task automatic set_pin(input int idx, input logic lvl);
    @(posedge clk);
    wake_pin[idx] <= lvl;
  endtask

  // Hold a pin active for a count of cycles, then release it
  task automatic hold_pin(input int idx, input logic lvl, input int cyc);
    @(posedge clk);
    wake_pin[idx] <= lvl;
    repeat (cyc) @(posedge clk);
    wake_pin[idx] <= ~lvl;
  endtask

  // One monitor detection
  task automatic mon_pulse;
    @(posedge clk);
    mon_detect <= 1'b1;
    repeat (4) @(posedge clk);
    mon_detect <= 1'b0;
  endtask

  // Brownout detector level
  task automatic set_bod(input logic lvl);
    @(posedge clk);
    brownout <= lvl;
  endtask

  // Live measurement and clock source levels
  task automatic set_live(input logic low, input logic src);
    @(posedge clk);
    mon_low <= low;
    slow_src <= src;
  endtask
endmodule

// ==== test/tb_supply_wakeup_status_logic.sv ====
`timescale 1ns/10ps
// Register-level test of the wake and supply status logic
module tb_supply_wakeup_status_logic;
  import supply_wake_pkg::*;
  localparam int SDIV = 4;
  logic        clk, rst, hsel, hwrite, hready, hresp, irq, core_wake, core_reset;
  logic        mon_detect, mon_low, brownout, slow_src;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, wake_count, reset_count;
  logic [15:0] wake_pin;
  logic [31:0] ctl  [3] = '{32'h0, 32'h10, 32'h20};
  logic [31:0] mexp [3] = '{32'h20, 32'h24, 32'h30};
  int          err_count = 0;
  int          check_count = 0;

  supply_wakeup_status_logic #(.SLOW_DIV(SDIV)) uut (
    .CLK(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready),
    .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp), .WAKE_PIN(wake_pin),
    .MON_DETECT(mon_detect), .MON_LOW(mon_low), .BROWNOUT(brownout),
    .SLOW_SRC_XTAL(slow_src), .CORE_WAKE(core_wake), .CORE_RESET(core_reset),
    .IRQ(irq));

  wake_partner p (
    .clk(clk), .wake_pin(wake_pin), .mon_detect(mon_detect), .mon_low(mon_low),
    .brownout(brownout), .slow_src(slow_src));

  // Clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Count wake and reset pulses
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wake_count <= 32'h0;
      reset_count <= 32'h0;
    end
    else
    begin
      if (core_wake === 1'b1) wake_count <= wake_count + 32'h1;
      if (core_reset === 1'b1) reset_count <= reset_count + 32'h1;
    end
  end

  // Verdict and end of run
  task automatic results;
    if (err_count == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Next edge with ready high, bounded
  task automatic wait_ready;
    int n;
    n = 0;
    @(posedge clk);
    while (hready !== 1'b1)
    begin
      n++;
      if (n > 50)
      begin
        err_count++;
        results();
      end
      @(posedge clk);
    end
  endtask

  // One AHB single word transfer
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= HTRANS_NONSEQ;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_ready();
    q = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input string name, input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(name, exp, q);
  endtask

  // Let a pending status clear land
  task automatic settle;
    repeat (4 * SDIV) @(posedge clk);
  endtask

  // Main sequence
  initial
  begin
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd("cfg reset", WAKE_CFG_ADDR, WAKE_CFG_RESET);
    rd("status reset", STATUS_ADDR, STICKY_RESET);
    rd("mask reset", IRQ_MASK_ADDR, IRQ_MASK_RESET);
    rd("ctrl reset", CONTROL_ADDR, CONTROL_RESET);
    rd("unmapped", CONTROL_ADDR + 32'h4, 32'h0);
    wr(STATUS_ADDR, 32'hffffffff);
    rd("status read only", STATUS_ADDR, 32'h0);
    wr(WAKE_CFG_ADDR, 32'h00010005);
    rd("cfg", WAKE_CFG_ADDR, 32'h00010005);
    p.hold_pin(1, 1'b1, 12);
    rd("disabled pin", STATUS_ADDR, 32'h0);
    p.hold_pin(0, 1'b1, 12);
    rd("rising wake", STATUS_ADDR, 32'h00010002);
    rd("before clear", STATUS_ADDR, 32'h00010002);
    settle();
    rd("after clear", STATUS_ADDR, 32'h0);
    p.set_pin(2, 1'b1);
    repeat (12) @(posedge clk);
    rd("wrong edge", STATUS_ADDR, 32'h0);
    p.hold_pin(2, 1'b0, 12);
    rd("falling wake", STATUS_ADDR, 32'h00040002);
    settle();
    wr(CONTROL_ADDR, 32'h1);
    p.hold_pin(0, 1'b1, 7);
    rd("short pulse", STATUS_ADDR, 32'h0);
    p.hold_pin(0, 1'b1, 24);
    rd("debounced", STATUS_ADDR, 32'h00010002);
    settle();
    // Monitor detection with neither, wake only and reset only set
    for (int i = 0; i < 3; i++)
    begin
      wr(CONTROL_ADDR, ctl[i]);
      p.mon_pulse();
      rd("monitor", STATUS_ADDR, mexp[i]);
      settle();
    end
    check("reset pulses", 32'h1, reset_count);
    check("wake pulses", 32'h4, wake_count);
    // Thirty-two tick debounce: thirty ticks too short, thirty-five enough
    wr(CONTROL_ADDR, 32'h2);
    p.hold_pin(0, 1'b1, 120);
    rd("long short", STATUS_ADDR, 32'h0);
    p.hold_pin(0, 1'b1, 140);
    rd("long debounced", STATUS_ADDR, 32'h00010002);
    settle();
    check("long wake pulses", 32'h5, wake_count);
    p.set_bod(1'b1);
    repeat (4) @(posedge clk);
    check("irq masked", 32'h0, {31'h0, irq});
    rd("bod rise", STATUS_ADDR, 32'h8);
    settle();
    rd("bod held", STATUS_ADDR, 32'h0);
    wr(IRQ_MASK_ADDR, 32'h8);
    rd("mask", IRQ_MASK_ADDR, 32'h8);
    p.set_bod(1'b0);
    repeat (4) @(posedge clk);
    p.set_bod(1'b1);
    repeat (4) @(posedge clk);
    check("irq set", 32'h1, {31'h0, irq});
    rd("bod again", STATUS_ADDR, 32'h8);
    settle();
    check("irq clear", 32'h0, {31'h0, irq});
    // Event while a clear pends survives that clear
    rd("pre event", STATUS_ADDR, 32'h0);
    p.set_bod(1'b0);
    p.set_bod(1'b1);
    settle();
    rd("set during clear", STATUS_ADDR, 32'h8);
    settle();
    p.set_live(1'b1, 1'b1);
    repeat (2) @(posedge clk);
    rd("live", STATUS_ADDR, 32'hc0);
    settle();
    rd("live kept", STATUS_ADDR, 32'hc0);
    check("okay", 32'h0, {31'h0, hresp});
    results();
  end
endmodule
